/* File: include/call_add_pkg.sv */
// Constants, opcodes and states for the call/add execute block
// Function
// RULE1: A call first advances the program counter by two; that is the return address.
// RULE2: Push return address: bump stack pointer, low byte, bump again, high byte.
// RULE3: Target keeps upper five counter bits, opcode bits 7-5, then second byte.
// RULE4: Only low eleven bits change, so target stays in the 2K region.
// RULE5: The call leaves carry, auxiliary carry and overflow untouched.
// RULE6: Add sums operand and accumulator with no carry in, result to accumulator.
// RULE7: Carry is carry out of bit 7; auxiliary carry is carry out of bit 3.
// RULE8: Overflow is set when exactly one of carries out of bits 6, 7 occurs.
// RULE9: Add operand comes from register, direct, register-indirect or immediate form.
// RULE10: Decode form from opcode low bits; fetch second byte for direct and immediate.
package call_add_pkg;

    // ==================================================================
    // Opcode decode
    localparam logic [4:0] CALL_LOW_BITS  = 5'h11;
    localparam logic [4:0] ADD_REG_TOP    = 5'h05;
    localparam logic [7:0] ADD_IMM_OPCODE = 8'h24;
    localparam logic [7:0] ADD_DIR_OPCODE = 8'h25;
    localparam logic [6:0] ADD_IND_TOP    = 7'h13;

    // ==================================================================
    // Lengths and reset values
    localparam logic [15:0] LEN_ONE_BYTE   = 16'h0001;
    localparam logic [15:0] LEN_TWO_BYTES  = 16'h0002;
    localparam logic [7:0]  SP_RESET       = 8'h07;
    localparam logic [15:0] PC_RESET       = 16'h0000;
    localparam logic [7:0]  ACC_RESET      = 8'h00;

    // ==================================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_CODE_WAIT = 3'b001,
        ST_PTR_WAIT  = 3'b010,
        ST_RAM_WAIT  = 3'b011,
        ST_EXEC      = 3'b100,
        ST_PUSH_HI   = 3'b101
    } exec_state_t;

endpackage : call_add_pkg

/* File: design/byte_adder_flags.sv */
// Eight-bit adder producing carry, auxiliary-carry and overflow
module byte_adder_flags
(
    input  wire logic [7:0] i_a,
    input  wire logic [7:0] i_b,
    output logic      [7:0] o_sum,
    output logic            o_carry,
    output logic            o_aux_carry,
    output logic            o_overflow
);
    logic [4:0] low_nibble;
    logic [7:0] low_seven;
    logic [8:0] full_sum;

    // No carry input: the sum takes the two operands alone
    assign low_nibble  = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};       // RULE6
    assign low_seven   = {1'b0, i_a[6:0]} + {1'b0, i_b[6:0]};
    assign full_sum    = {1'b0, i_a} + {1'b0, i_b};                 // RULE6
    assign o_sum       = full_sum[7:0];
    assign o_carry     = full_sum[8];                               // RULE7
    assign o_aux_carry = low_nibble[4];                             // RULE7
    assign o_overflow  = full_sum[8] ^ low_seven[7];                // RULE8

endmodule : byte_adder_flags

/* File: design/absolute_call_and_add_exec.sv */
// Execute-stage sequencer for the absolute subroutine call and the accumulator add
module absolute_call_and_add_exec
    import call_add_pkg::*;
(
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST_B,
    input  wire logic        i_start,
    input  wire logic [7:0]  i_opcode,
    input  wire logic [15:0] i_pc,
    input  wire logic [7:0]  i_sp,
    input  wire logic [7:0]  i_acc,
    input  wire logic [1:0]  i_bank_sel,
    input  wire logic        i_carry_flag,
    input  wire logic        i_aux_carry_flag,
    input  wire logic        i_overflow_flag,
    input  wire logic [7:0]  i_code_data,
    input  wire logic [7:0]  i_ram_rdata,
    output logic             o_code_rd,
    output logic      [15:0] o_code_addr,
    output logic             o_ram_rd,
    output logic             o_ram_we,
    output logic      [7:0]  o_ram_addr,
    output logic      [7:0]  o_ram_wdata,
    output logic      [15:0] o_pc,
    output logic      [7:0]  o_sp,
    output logic      [7:0]  o_acc,
    output logic             o_carry_flag,
    output logic             o_aux_carry_flag,
    output logic             o_overflow_flag,
    output logic             o_busy,
    output logic             o_done
);
    // ==================================================================
    // Helpers
    function automatic logic [7:0] inc8(input logic [7:0] v);
        inc8 = v + 8'h01;
    endfunction : inc8

    function automatic logic [15:0] pc_add(input logic [15:0] pc, input logic [15:0] n);
        pc_add = pc + n;
    endfunction : pc_add

    // ==================================================================
    // State
    exec_state_t state_reg, state_next;
    logic [7:0]  op_reg, op_next;
    logic [7:0]  byte2_reg, byte2_next;
    logic [7:0]  opnd_reg, opnd_next;
    logic [15:0] ret_reg, ret_next;
    logic [15:0] pc_reg, pc_next;
    logic [7:0]  sp_reg, sp_next;
    logic [7:0]  acc_reg, acc_next;
    logic        cy_reg, cy_next;
    logic        ac_reg, ac_next;
    logic        ov_reg, ov_next;
    logic [1:0]  bank_reg, bank_next;
    logic        code_rd_reg, code_rd_next;
    logic [15:0] code_addr_reg, code_addr_next;
    logic        ram_rd_reg, ram_rd_next;
    logic        ram_we_reg, ram_we_next;
    logic [7:0]  ram_addr_reg, ram_addr_next;
    logic [7:0]  wdata_reg, wdata_next;
    logic        busy_reg, busy_next;
    logic        done_reg, done_next;

    // ==================================================================
    // Decode
    wire        new_is_call = (i_opcode[4:0] == CALL_LOW_BITS);                  // RULE10
    wire        new_is_reg  = (i_opcode[7:3] == ADD_REG_TOP);                    // RULE9
    wire        new_is_ind  = (i_opcode[7:1] == ADD_IND_TOP);                    // RULE9
    wire        new_is_dir  = (i_opcode == ADD_DIR_OPCODE);                      // RULE9
    wire        new_is_imm  = (i_opcode == ADD_IMM_OPCODE);                      // RULE9
    wire        new_two     = new_is_call | new_is_dir | new_is_imm;             // RULE10
    wire        op_is_call  = (op_reg[4:0] == CALL_LOW_BITS);
    wire        op_is_dir   = (op_reg == ADD_DIR_OPCODE);
    wire        op_is_imm   = (op_reg == ADD_IMM_OPCODE);
    wire [7:0]  reg_addr    = {3'b000, i_bank_sel, i_opcode[2:0]};
    wire [7:0]  ptr_addr    = {3'b000, i_bank_sel, 2'b00, i_opcode[0]};
    wire [15:0] add_len     = (op_is_dir | op_is_imm) ? LEN_TWO_BYTES : LEN_ONE_BYTE;
    wire [15:0] call_target = {ret_reg[15:11], op_reg[7:5], byte2_reg};         // RULE3 RULE4

    logic [7:0] sum_w;
    logic       cy_w;
    logic       ac_w;
    logic       ov_w;

    byte_adder_flags u_adder
    (
        .i_a         (acc_reg),
        .i_b         (opnd_reg),
        .o_sum       (sum_w),
        .o_carry     (cy_w),
        .o_aux_carry (ac_w),
        .o_overflow  (ov_w)
    );

    // ==================================================================
    // Sequencer
    always_comb
    begin
        state_next     = state_reg;
        op_next        = op_reg;
        byte2_next     = byte2_reg;
        opnd_next      = opnd_reg;
        ret_next       = ret_reg;
        pc_next        = pc_reg;
        sp_next        = sp_reg;
        acc_next       = acc_reg;
        cy_next        = cy_reg;
        ac_next        = ac_reg;
        ov_next        = ov_reg;
        bank_next      = bank_reg;
        code_rd_next   = 1'b0;
        code_addr_next = code_addr_reg;
        ram_rd_next    = 1'b0;
        ram_we_next    = 1'b0;
        ram_addr_next  = ram_addr_reg;
        wdata_next     = wdata_reg;
        done_next      = 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (i_start)
                begin
                    op_next   = i_opcode;
                    pc_next   = i_pc;
                    sp_next   = i_sp;
                    acc_next  = i_acc;
                    cy_next   = i_carry_flag;
                    ac_next   = i_aux_carry_flag;
                    ov_next   = i_overflow_flag;
                    bank_next = i_bank_sel;
                    if (new_two)
                    begin
                        code_rd_next   = 1'b1;                                   // RULE10
                        code_addr_next = pc_add(i_pc, LEN_ONE_BYTE);
                        state_next     = ST_CODE_WAIT;
                    end
                    else if (new_is_reg)
                    begin
                        ram_rd_next   = 1'b1;
                        ram_addr_next = reg_addr;
                        state_next    = ST_RAM_WAIT;
                    end
                    else if (new_is_ind)
                    begin
                        ram_rd_next   = 1'b1;
                        ram_addr_next = ptr_addr;
                        state_next    = ST_PTR_WAIT;
                    end
                    else
                    begin
                        // Foreign opcode: acknowledged, nothing altered
                        done_next = 1'b1;
                    end
                end
            end
            ST_CODE_WAIT:
            begin
                byte2_next = i_code_data;
                if (op_is_call)
                begin
                    ret_next      = pc_add(pc_reg, LEN_TWO_BYTES);               // RULE1
                    sp_next       = inc8(sp_reg);                                // RULE2
                    ram_we_next   = 1'b1;
                    ram_addr_next = inc8(sp_reg);
                    wdata_next    = ret_next[7:0];                               // RULE2
                    state_next    = ST_PUSH_HI;
                end
                else if (op_is_imm)
                begin
                    opnd_next  = i_code_data;                                    // RULE9
                    state_next = ST_EXEC;
                end
                else
                begin
                    ram_rd_next   = 1'b1;
                    ram_addr_next = i_code_data;                                 // RULE9
                    state_next    = ST_RAM_WAIT;
                end
            end
            ST_PTR_WAIT:
            begin
                ram_rd_next   = 1'b1;
                ram_addr_next = i_ram_rdata;                                     // RULE9
                state_next    = ST_RAM_WAIT;
            end
            ST_RAM_WAIT:
            begin
                opnd_next  = i_ram_rdata;
                state_next = ST_EXEC;
            end
            ST_EXEC:
            begin
                acc_next   = sum_w;                                              // RULE6
                cy_next    = cy_w;                                               // RULE7
                ac_next    = ac_w;                                               // RULE7
                ov_next    = ov_w;                                               // RULE8
                pc_next    = pc_add(pc_reg, add_len);
                done_next  = 1'b1;
                state_next = ST_IDLE;
            end
            ST_PUSH_HI:
            begin
                sp_next       = inc8(sp_reg);                                    // RULE2
                ram_we_next   = 1'b1;
                ram_addr_next = inc8(sp_reg);
                wdata_next    = ret_reg[15:8];                                   // RULE2
                pc_next       = call_target;                                     // RULE3 RULE4
                done_next     = 1'b1;
                state_next    = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        busy_next = (state_next != ST_IDLE);
    end

    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_B)
        begin
            state_reg     <= ST_IDLE;
            op_reg        <= 8'h00;
            byte2_reg     <= 8'h00;
            opnd_reg      <= 8'h00;
            ret_reg       <= PC_RESET;
            pc_reg        <= PC_RESET;
            sp_reg        <= SP_RESET;
            acc_reg       <= ACC_RESET;
            cy_reg        <= 1'b0;
            ac_reg        <= 1'b0;
            ov_reg        <= 1'b0;
            bank_reg      <= 2'h0;
            code_rd_reg   <= 1'b0;
            code_addr_reg <= PC_RESET;
            ram_rd_reg    <= 1'b0;
            ram_we_reg    <= 1'b0;
            ram_addr_reg  <= 8'h00;
            wdata_reg     <= 8'h00;
            busy_reg      <= 1'b0;
            done_reg      <= 1'b0;
        end
        else
        begin
            state_reg     <= state_next;
            op_reg        <= op_next;
            byte2_reg     <= byte2_next;
            opnd_reg      <= opnd_next;
            ret_reg       <= ret_next;
            pc_reg        <= pc_next;
            sp_reg        <= sp_next;
            acc_reg       <= acc_next;
            cy_reg        <= cy_next;                                            // RULE5
            ac_reg        <= ac_next;                                            // RULE5
            ov_reg        <= ov_next;                                            // RULE5
            bank_reg      <= bank_next;
            code_rd_reg   <= code_rd_next;
            code_addr_reg <= code_addr_next;
            ram_rd_reg    <= ram_rd_next;
            ram_we_reg    <= ram_we_next;
            ram_addr_reg  <= ram_addr_next;
            wdata_reg     <= wdata_next;
            busy_reg      <= busy_next;
            done_reg      <= done_next;
        end
    end

    assign o_code_rd        = code_rd_reg;
    assign o_code_addr      = code_addr_reg;
    assign o_ram_rd         = ram_rd_reg;
    assign o_ram_we         = ram_we_reg;
    assign o_ram_addr       = ram_addr_reg;
    assign o_ram_wdata      = wdata_reg;
    assign o_pc             = pc_reg;
    assign o_sp             = sp_reg;
    assign o_acc            = acc_reg;
    assign o_carry_flag     = cy_reg;
    assign o_aux_carry_flag = ac_reg;
    assign o_overflow_flag  = ov_reg;
    assign o_busy           = busy_reg;
    assign o_done           = done_reg;

    // ==================================================================
    // Checks
    wire [8:0] chk_sum9 = {1'b0, acc_reg} + {1'b0, opnd_reg};
    wire [7:0] chk_sum7 = {1'b0, acc_reg[6:0]} + {1'b0, opnd_reg[6:0]};
    wire [4:0] chk_sum4 = {1'b0, acc_reg[3:0]} + {1'b0, opnd_reg[3:0]};

    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_B);

    sequence push_lo_s;
        (state_reg == ST_PUSH_HI) && o_ram_we && (o_ram_addr == o_sp)
            && (o_ram_wdata == ret_reg[7:0]);
    endsequence

    sequence push_hi_s(logic [7:0] sp0, logic [7:0] hi);
        o_ram_we && (o_sp == sp0 + 8'h01) && (o_ram_addr == o_sp)
            && (o_ram_wdata == hi) && o_done;
    endsequence

    return_addr_a: assert property ((state_reg == ST_PUSH_HI) |-> ret_reg == pc_reg + 16'h0002) // RULE1
        else $error("return address is not call address plus two");
    stack_push_a: assert property ((state_reg == ST_CODE_WAIT) && op_is_call
        |=> push_lo_s ##1 push_hi_s($past(o_sp), $past(ret_reg[15:8]))) // RULE2
        else $error("return address push order or stack pointer wrong");
    call_target_a: assert property ((state_reg == ST_PUSH_HI)
        |=> o_pc == {$past(ret_reg[15:11]), $past(op_reg[7:5]), $past(byte2_reg)}) // RULE3
        else $error("call target not built from page bits");
    same_region_a: assert property ((state_reg == ST_PUSH_HI) |=> o_pc[15:11] == $past(ret_reg[15:11])) // RULE4
        else $error("call left its 2K region");
    flags_kept_a: assert property ((state_reg != ST_EXEC) && !(state_reg == ST_IDLE && i_start)
        |=> $stable({o_carry_flag, o_aux_carry_flag, o_overflow_flag})) // RULE5
        else $error("flags changed outside an add");
    add_result_a: assert property ((state_reg == ST_EXEC) |=> o_acc == $past(chk_sum9[7:0]) && o_done) // RULE6
        else $error("add result wrong");
    add_carries_a: assert property ((state_reg == ST_EXEC)
        |=> o_carry_flag == $past(chk_sum9[8]) && o_aux_carry_flag == $past(chk_sum4[4])) // RULE7
        else $error("carry or auxiliary carry wrong");
    add_overflow_a: assert property ((state_reg == ST_EXEC)
        |=> o_overflow_flag == ($past(chk_sum9[8]) != $past(chk_sum7[7]))) // RULE8
        else $error("overflow flag wrong");
    indirect_chain_a: assert property ((state_reg == ST_PTR_WAIT)
        |=> o_ram_rd && o_ram_addr == $past(i_ram_rdata) ##1 (state_reg == ST_EXEC)) // RULE9
        else $error("indirect operand not fetched through pointer");
    fetch_second_a: assert property ((state_reg == ST_IDLE) && i_start
        |=> o_code_rd == $past(new_two)) // RULE10
        else $error("second byte fetch decision wrong");

endmodule : absolute_call_and_add_exec

/* File: dv/mem_partner.sv */
// Behavioural program memory and internal RAM answering the execute block
module mem_partner
(
    input  wire logic        i_clock,
    input  wire logic        i_code_rd,
    input  wire logic [15:0] i_code_addr,
    input  wire logic        i_ram_rd,
    input  wire logic        i_ram_we,
    input  wire logic [7:0]  i_ram_addr,
    input  wire logic [7:0]  i_ram_wdata,
    output logic      [7:0]  o_code_data,
    output logic      [7:0]  o_ram_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] code_mem [0:65535];
    logic [7:0] ram_mem  [0:255];
    logic [7:0] code_idle;
    logic [7:0] ram_idle;
    int         n_writes;

    initial
    begin
        code_idle = 8'h5a;
        ram_idle  = 8'ha5;
        n_writes  = 0;
    end

    // ==========================================================
    // Read answer
    // Data stands only while the registered strobe is up; the toggling idle value exposes
    // any sampling outside that cycle
    assign o_code_data = i_code_rd ? code_mem[i_code_addr] : code_idle;
    assign o_ram_rdata = i_ram_rd ? ram_mem[i_ram_addr] : ram_idle;

    always @(posedge i_clock)
    begin
        code_idle <= ~code_idle;
        ram_idle  <= ~ram_idle;
        if (i_ram_we)
        begin
            ram_mem[i_ram_addr] <= i_ram_wdata;
            n_writes            <= n_writes + 1;
        end
    end
endmodule : mem_partner

/* File: dv/tb_top.sv */
// Self-checking bench for the call/add execute block
module tb_top;
    import call_add_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DLY = 5;

    logic        clk, rst_b, start, cy_in, ac_in, ov_in, code_rd, ram_rd, ram_we;
    logic [7:0]  opcode, sp_in, acc_in, code_data, ram_rdata, ram_addr, ram_wdata;
    logic [7:0]  sp_out, acc_out;
    logic [1:0]  bank;
    logic [15:0] pc_in, code_addr, pc_out;
    logic        cy_out, ac_out, ov_out, busy, done;
    int          n_fail, cmp_count;
    logic [7:0]  op_tab [7] = '{8'h11, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h00};

    absolute_call_and_add_exec dut (.I_CLOCK(clk), .I_RST_B(rst_b), .i_start(start),
        .i_opcode(opcode), .i_pc(pc_in), .i_sp(sp_in), .i_acc(acc_in), .i_bank_sel(bank),
        .i_carry_flag(cy_in), .i_aux_carry_flag(ac_in), .i_overflow_flag(ov_in),
        .i_code_data(code_data), .i_ram_rdata(ram_rdata), .o_code_rd(code_rd),
        .o_code_addr(code_addr), .o_ram_rd(ram_rd), .o_ram_we(ram_we), .o_ram_addr(ram_addr),
        .o_ram_wdata(ram_wdata), .o_pc(pc_out), .o_sp(sp_out), .o_acc(acc_out),
        .o_carry_flag(cy_out), .o_aux_carry_flag(ac_out), .o_overflow_flag(ov_out),
        .o_busy(busy), .o_done(done));

    mem_partner mem (.i_clock(clk), .i_code_rd(code_rd), .i_code_addr(code_addr),
        .i_ram_rd(ram_rd), .i_ram_we(ram_we), .i_ram_addr(ram_addr), .i_ram_wdata(ram_wdata),
        .o_code_data(code_data), .o_ram_rdata(ram_rdata));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic give_verdict();
        if (n_fail == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : check

    // ==========================================================
    // One instruction: reference model, issue, bounded wait, compare
    task automatic run(input logic [7:0] op, input logic [15:0] pc, input logic [7:0] sp,
                       input logic [7:0] acc, input logic [1:0] bk, input logic [2:0] fl,
                       input logic [7:0] b2);
        logic [15:0] ret, e_pc;
        logic [7:0]  e_sp, e_acc, opnd;
        logic [2:0]  e_fl;
        logic [8:0]  sum;
        int          lat, cyc, w0, kind;
        ret  = pc + 16'h0002;
        kind = 0;
        mem.code_mem[pc + 16'h0001] = b2;
        e_sp = sp;
        e_acc = acc;
        e_fl = fl;
        e_pc = pc;
        lat  = 1;
        opnd = 8'h00;
        casez (op)
            8'b???10001: begin e_pc = {ret[15:11], op[7:5], b2}; e_sp = sp + 8'h02; lat = 3;
                               kind = 1; end
            8'b00101???: begin opnd = mem.ram_mem[{3'b000, bk, op[2:0]}]; lat = 3; kind = 2; end
            8'h24:       begin opnd = b2; lat = 3; kind = 2; end
            8'h25:       begin opnd = mem.ram_mem[b2]; lat = 4; kind = 2; end
            8'h26, 8'h27: begin opnd = mem.ram_mem[mem.ram_mem[{3'b000, bk, 2'b00, op[0]}]];
                               lat = 4; kind = 2; end
            default:     lat = 1;
        endcase
        if (kind == 2)
        begin
            sum   = {1'b0, acc} + {1'b0, opnd};
            e_acc = sum[7:0];
            e_fl[2] = sum[8];
            e_fl[1] = ({1'b0, acc[3:0]} + {1'b0, opnd[3:0]}) > 5'h0f;
            e_fl[0] = sum[8] ^ (({1'b0, acc[6:0]} + {1'b0, opnd[6:0]}) > 8'h7f);
            e_pc  = pc + ((op == 8'h24 || op == 8'h25) ? 16'h0002 : 16'h0001);
        end
        w0 = mem.n_writes;
        start = 1'b1;
        opcode = op;
        pc_in = pc;
        sp_in = sp;
        acc_in = acc;
        bank = bk;
        {cy_in, ac_in, ov_in} = fl;
        @(posedge clk);
        #DLY;
        cyc = 1;
        while (done !== 1'b1 && cyc < 20)
        begin
            // A stray issue while busy must be ignored
            start  = (cyc == 1 && lat > 2);
            opcode = 8'h00;
            acc_in = ~acc;
            @(posedge clk);
            #DLY;
            cyc++;
        end
        if (cyc >= 20)
        begin
            n_fail++;
            give_verdict();
        end
        check(16'(cyc), 16'(lat));
        check(pc_out, e_pc);
        check({8'h00, sp_out}, {8'h00, e_sp});
        check({8'h00, acc_out}, {8'h00, e_acc});
        check({13'h0000, cy_out, ac_out, ov_out}, {13'h0000, e_fl});
        if (kind == 1)
        begin
            // Last push lands on the edge after the done cycle
            @(posedge clk);
            #DLY;
            check({8'h00, mem.ram_mem[sp + 8'h01]}, {8'h00, ret[7:0]});
            check({8'h00, mem.ram_mem[sp + 8'h02]}, {8'h00, ret[15:8]});
        end
        check(16'(mem.n_writes - w0), (kind == 1) ? 16'h0002 : 16'h0000);
        if (lat == 1)
        begin
            // Foreign op leaves the strobe up; drop it across one idle edge
            start = 1'b0;
            @(posedge clk);
            #DLY;
        end
    endtask : run

    initial
    begin
        logic [7:0] op;
        int         i;
        n_fail = 0;
        cmp_count = 0;
        {start, opcode, pc_in, sp_in, acc_in, bank, cy_in, ac_in, ov_in} = '0;
        rst_b = 1'b0;
        void'($urandom(32'hec370131));
        for (i = 0; i < 256; i++)
            mem.ram_mem[i] = 8'($urandom);
        repeat (3) @(posedge clk);
        #DLY;
        rst_b = 1'b1;
        check(pc_out, PC_RESET);
        check({busy, done, sp_out, acc_out}, {2'b00, SP_RESET, ACC_RESET});
        mem.ram_mem[0] = 8'haa;
        run(8'h28, 16'h0100, 8'h07, 8'hc3, 2'b00, 3'b010, 8'h00);
        run(8'h71, 16'h0123, 8'h07, 8'h00, 2'b00, 3'b111, 8'h45);
        run(8'hf1, 16'h07fe, 8'hfe, 8'h11, 2'b01, 3'b101, 8'hff);
        run(8'h11, 16'hfffe, 8'hff, 8'h22, 2'b10, 3'b000, 8'h00);
        for (i = 0; i < 120; i++)
        begin
            op = op_tab[$urandom_range(0, 6)];
            if (op == 8'h11)
                op[7:5] = 3'($urandom);
            if (op == 8'h28)
                op[2:0] = 3'($urandom);
            run(op, 16'($urandom), 8'($urandom), 8'($urandom), 2'($urandom),
                3'($urandom), 8'($urandom));
        end
        give_verdict();
    end
endmodule : tb_top
